// >>> tqim_params.svh
// Constants for the dual-channel torque inhibit monitor.
// Assumes a single 40 MHz clock; included by the package and the top module.
`ifndef TQIM_PARAMS_SVH
`define TQIM_PARAMS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TQIM_CLK_PERIOD_NS 25
// Longest tolerated channel skew before a mismatch trips, in ns
`define TQIM_SKEW_NS 1000
`define TQIM_SKEW_CYCLES ((`TQIM_SKEW_NS) / (`TQIM_CLK_PERIOD_NS))

// ----------------------------------------------------------------------
// Indication setting codes (2 bits)
// ----------------------------------------------------------------------
`define TQIM_IND_NONE 2'h0
`define TQIM_IND_WARN 2'h1
`define TQIM_IND_FAULT 2'h2

// ----------------------------------------------------------------------
// Diagnostic output bit positions
// ----------------------------------------------------------------------
`define TQIM_DIAG_CH1 0
`define TQIM_DIAG_CH2 1
`define TQIM_DIAG_INH_FAULT 2
`define TQIM_DIAG_INH_WARN 3
`define TQIM_DIAG_W 4

`endif

// >>> tqim_pkg.sv
// Types for the dual-channel torque inhibit monitor.
// Assumes tqim_params.svh is on the include path.
`include "tqim_params.svh"

package tqim_pkg;
    // Drive control state, one-hot
    typedef enum logic [3:0] {
        TQIM_ST_STOPPED = 4'b0001,
        TQIM_ST_RUNNING = 4'b0010,
        TQIM_ST_INHIBIT = 4'b0100,
        TQIM_ST_FAULT = 4'b1000
    } tqim_state_e;
endpackage

// >>> tqim_monitor.sv
// Dual-channel torque inhibit monitor: gate drive cut, start blocking,
// channel cross-compare and fault latch.
// Assumes inhibit contact inputs are high when closed (energised).
`include "tqim_params.svh"

module tqim_monitor #(
    parameter int unsigned SKEW_CYCLES = `TQIM_SKEW_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Inhibit channel contacts, high when closed
    input wire logic inhibit_ch1,
    input wire logic inhibit_ch2,
    // Drive commands
    input wire logic start_cmd,
    input wire logic stop_cmd,
    input wire logic fault_reset,
    input wire logic [1:0] ind_run_sel,
    input wire logic [1:0] ind_stop_sel,
    // Power stage and status
    output logic gate_enable,
    output logic motor_running,
    output logic torque_inhibit,
    output logic inhibit_warning,
    output logic inhibit_fault,
    output logic channel_one_inhibit_fault,
    output logic channel_two_inhibit_fault,
    output logic [`TQIM_DIAG_W-1:0] diag_out
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [1:0] sync1_q, sync1_d;
    logic [1:0] sync2_q, sync2_d;
    logic start_q, start_d;

    // Two-flop sync; first stage feeds only the second
    always_comb begin
        sync1_d = {inhibit_ch2, inhibit_ch1};
        sync2_d = sync1_q;
        start_d = start_cmd;
    end

    // Reset drives contacts open so the drive comes up inhibited
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
            start_q <= 1'b0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            start_q <= start_d;
        end
    end

    logic ch1_closed, ch2_closed, both_closed, any_open, mismatch, start_edge;
    // Decoded channel conditions
    assign ch1_closed = sync2_q[0];
    assign ch2_closed = sync2_q[1];
    assign both_closed = ch1_closed & ch2_closed;
    assign any_open = ~both_closed;
    assign mismatch = ch1_closed ^ ch2_closed;
    assign start_edge = start_cmd & ~start_q;

    // ------------------------------------------------------------------
    // Discrepancy timer and control state
    // ------------------------------------------------------------------
    // Skew timer allows contacts to switch at slightly different times
    logic [15:0] skew_q, skew_d;
    tqim_pkg::tqim_state_e state_q, state_d;
    logic f1_q, f1_d, f2_q, f2_d;
    logic warn_q, warn_d, ifault_q, ifault_d;
    logic need_edge_q, need_edge_d;
    logic [1:0] sel;
    logic trip;
    logic start_req;

    always_comb begin
        skew_d = mismatch ? ((skew_q < 16'(SKEW_CYCLES)) ? skew_q + 16'h0001 : skew_q) : 16'h0000;
        trip = mismatch && (skew_q >= 16'(SKEW_CYCLES));
        // Stop held high blocks a start, so the state cannot toggle each cycle
        start_req = (start_edge || (start_cmd && !need_edge_q)) && !stop_cmd;
        state_d = state_q;
        f1_d = f1_q;
        f2_d = f2_q;
        warn_d = warn_q;
        ifault_d = ifault_q;
        need_edge_d = need_edge_q;
        sel = (state_q == tqim_pkg::TQIM_ST_RUNNING) ? ind_run_sel : ind_stop_sel;
        // Latch channel-specific faults; set wins over reset
        if (trip && !ch1_closed) f1_d = 1'b1;
        else if (fault_reset) f1_d = 1'b0;
        if (trip && !ch2_closed) f2_d = 1'b1;
        else if (fault_reset) f2_d = 1'b0;
        unique case (state_q)
            tqim_pkg::TQIM_ST_STOPPED: begin
                // Level start after reset may run without edge; after an inhibit or trip an edge is needed
                if (any_open) begin
                    state_d = tqim_pkg::TQIM_ST_INHIBIT;
                    need_edge_d = 1'b1;
                    warn_d = (sel == `TQIM_IND_WARN);
                    // A latched fault indication is kept until a fault reset
                    ifault_d = ifault_q || (sel == `TQIM_IND_FAULT);
                end else if (start_req && !f1_q && !f2_q && !ifault_q) begin
                    state_d = tqim_pkg::TQIM_ST_RUNNING;
                end
            end
            tqim_pkg::TQIM_ST_RUNNING: begin
                if (any_open) begin
                    state_d = tqim_pkg::TQIM_ST_INHIBIT;
                    need_edge_d = 1'b1;
                    warn_d = (sel == `TQIM_IND_WARN);
                    ifault_d = ifault_q || (sel == `TQIM_IND_FAULT);
                end else if (stop_cmd || !start_cmd) begin
                    state_d = tqim_pkg::TQIM_ST_STOPPED;
                end
            end
            tqim_pkg::TQIM_ST_INHIBIT: begin
                // Edge demand is set on entry only, so power-up needs no edge
                if (trip) begin
                    state_d = tqim_pkg::TQIM_ST_FAULT;
                end else if (both_closed) begin
                    state_d = tqim_pkg::TQIM_ST_STOPPED;
                    warn_d = 1'b0;
                end
            end
            tqim_pkg::TQIM_ST_FAULT: begin
                // Leave only with contacts closed and faults reset
                if (both_closed && fault_reset) begin
                    state_d = tqim_pkg::TQIM_ST_STOPPED;
                    warn_d = 1'b0;
                end
            end
            default: state_d = tqim_pkg::TQIM_ST_INHIBIT;
        endcase
        if (trip) begin
            state_d = tqim_pkg::TQIM_ST_FAULT;
            need_edge_d = 1'b1;
        end
        // Inhibit-indication fault cleared by reset once contacts close
        if (fault_reset && both_closed && state_d != tqim_pkg::TQIM_ST_INHIBIT) ifault_d = 1'b0;
        // Edge demand is met only by actually starting, not by a refused start
        if (state_d == tqim_pkg::TQIM_ST_RUNNING) need_edge_d = 1'b0;
    end

    // Control registers; need_edge cleared at reset so a held start may run
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= tqim_pkg::TQIM_ST_INHIBIT;
            skew_q <= 16'h0000;
            f1_q <= 1'b0;
            f2_q <= 1'b0;
            warn_q <= 1'b0;
            ifault_q <= 1'b0;
            need_edge_q <= 1'b0;
        end else begin
            state_q <= state_d;
            skew_q <= skew_d;
            f1_q <= f1_d;
            f2_q <= f2_d;
            warn_q <= warn_d;
            ifault_q <= ifault_d;
            need_edge_q <= need_edge_d;
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    logic gate_q, gate_d, run_q, run_d, inh_q, inh_d;
    logic [`TQIM_DIAG_W-1:0] diag_q, diag_d;

    // Gate enabled only when running with both channels closed this cycle
    always_comb begin
        run_d = (state_d == tqim_pkg::TQIM_ST_RUNNING);
        gate_d = run_d && both_closed;
        inh_d = any_open;
        diag_d = '0;
        diag_d[`TQIM_DIAG_CH1] = f1_d;
        diag_d[`TQIM_DIAG_CH2] = f2_d;
        diag_d[`TQIM_DIAG_INH_FAULT] = ifault_d;
        diag_d[`TQIM_DIAG_INH_WARN] = warn_d;
    end

    // Output flops; reset shows gate off and inhibit active
    always_ff @(posedge clk) begin
        if (rst) begin
            gate_q <= 1'b0;
            run_q <= 1'b0;
            inh_q <= 1'b1;
            diag_q <= '0;
        end else begin
            gate_q <= gate_d;
            run_q <= run_d;
            inh_q <= inh_d;
            diag_q <= diag_d;
        end
    end

    assign gate_enable = gate_q;
    assign motor_running = run_q;
    assign torque_inhibit = inh_q;
    assign inhibit_warning = diag_q[`TQIM_DIAG_INH_WARN];
    assign inhibit_fault = diag_q[`TQIM_DIAG_INH_FAULT];
    assign channel_one_inhibit_fault = diag_q[`TQIM_DIAG_CH1];
    assign channel_two_inhibit_fault = diag_q[`TQIM_DIAG_CH2];
    assign diag_out = diag_q;

endmodule // tqim_monitor

// >>> tqim_contacts.sv
// Behavioural model of the external activation switch, two contacts.
// Assumes the bench commands opening per channel; contact closed gives 1.
module tqim_contacts (
    // Clock and command
    input wire logic clk,
    input wire logic [1:0] open_req,
    // Contact lines towards the monitor
    output logic inhibit_ch1,
    output logic inhibit_ch2
);
    timeunit 1ns;
    timeprecision 1ps;
    // Contacts follow the command one edge late, like a slow relay
    always @(posedge clk) begin
        inhibit_ch1 <= ~open_req[0];
        inhibit_ch2 <= ~open_req[1];
    end
endmodule // tqim_contacts

// >>> tqim_chk_monitor.sv
// Concurrent checks on the torque inhibit monitor ports.
// Assumes one clock domain and a synchronous active-high reset.
module tqim_chk #(
    parameter int unsigned SKEW_CYCLES = 40
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inhibit_ch1,
    input wire logic inhibit_ch2,
    input wire logic fault_reset,
    input wire logic gate_enable,
    input wire logic motor_running,
    input wire logic torque_inhibit,
    input wire logic inhibit_fault,
    input wire logic channel_one_inhibit_fault,
    input wire logic channel_two_inhibit_fault,
    input wire logic [3:0] diag_out
);
    logic [7:0] mis_q;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Raw mismatch length, saturating so long trips do not wrap
    always_ff @(posedge clk) begin
        mis_q <= (rst || inhibit_ch1 == inhibit_ch2) ? 8'h00 : mis_q + {7'h00, mis_q != 8'hff};
    end
    chk_gate_inhibit: assert property (torque_inhibit |-> !gate_enable)
        else $error("gate drive on during inhibit");
    chk_open_cut: assert property ((!inhibit_ch1 || !inhibit_ch2) [*3] |=> torque_inhibit && !gate_enable)
        else $error("open contact did not cut gate drive");
    chk_start_block: assert property (torque_inhibit |=> !motor_running)
        else $error("motor running while inhibited");
    chk_fault_norun: assert property ((inhibit_fault || channel_one_inhibit_fault || channel_two_inhibit_fault) |-> !gate_enable)
        else $error("gate drive on with fault latched");
    // Count two edges back covers the mismatch samples that caused the trip
    chk_skew_trip: assert property ($rose(channel_one_inhibit_fault) |-> $past(mis_q, 2) > SKEW_CYCLES)
        else $error("channel one fault without lasting mismatch");
    chk_ch2_side: assert property ($rose(channel_two_inhibit_fault) |-> $past(inhibit_ch1, 3) && !$past(inhibit_ch2, 3))
        else $error("channel two fault with wrong channel open");
    chk_reset_clear: assert property ($fell(inhibit_fault) |-> $past(fault_reset))
        else $error("fault cleared without fault reset");
    chk_diag_route: assert property (diag_out[2:0] == {inhibit_fault, channel_two_inhibit_fault, channel_one_inhibit_fault})
        else $error("channel two fault not on diagnostic output");
    cover property ($rose(channel_one_inhibit_fault));
    cover property ($rose(channel_two_inhibit_fault));
    cover property ($rose(motor_running));
endmodule // tqim_chk
bind tqim_monitor tqim_chk #(.SKEW_CYCLES(SKEW_CYCLES)) i_tqim_chk (.clk(clk), .rst(rst), .inhibit_ch1(inhibit_ch1),
    .inhibit_ch2(inhibit_ch2), .fault_reset(fault_reset), .gate_enable(gate_enable), .motor_running(motor_running),
    .torque_inhibit(torque_inhibit), .inhibit_fault(inhibit_fault), .diag_out(diag_out),
    .channel_one_inhibit_fault(channel_one_inhibit_fault), .channel_two_inhibit_fault(channel_two_inhibit_fault));

// >>> tqim_monitor_tb.sv
// Self-checking bench for the torque inhibit monitor.
// Assumes the contact model and the bound checker are compiled before it.
module tqim_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, start_cmd = 1, stop_cmd = 0, fault_reset = 0;
    logic [1:0] open_req = 0, ind_run_sel = 0, ind_stop_sel = 0;
    logic inhibit_ch1, inhibit_ch2, gate_enable, motor_running, torque_inhibit;
    logic inhibit_warning, inhibit_fault, channel_one_inhibit_fault, channel_two_inhibit_fault;
    logic [3:0] diag_out;
    int error_cnt = 0, n_checks = 0, cyc_cnt = 0;
    always #12.5 clk = ~clk;
    tqim_contacts i_tqim_contacts (.clk(clk), .open_req(open_req), .inhibit_ch1(inhibit_ch1),
        .inhibit_ch2(inhibit_ch2));
    tqim_monitor #(.SKEW_CYCLES(2)) i_tqim_monitor (.clk(clk), .rst(rst), .inhibit_ch1(inhibit_ch1),
        .inhibit_ch2(inhibit_ch2), .start_cmd(start_cmd), .stop_cmd(stop_cmd), .fault_reset(fault_reset),
        .ind_run_sel(ind_run_sel), .ind_stop_sel(ind_stop_sel), .gate_enable(gate_enable),
        .motor_running(motor_running), .torque_inhibit(torque_inhibit), .inhibit_warning(inhibit_warning),
        .inhibit_fault(inhibit_fault), .channel_one_inhibit_fault(channel_one_inhibit_fault),
        .channel_two_inhibit_fault(channel_two_inhibit_fault), .diag_out(diag_out));
    // Inputs move 2 ns after the edge, clear of sampling
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task chk(input logic [3:0] seen, input logic [3:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Fresh rising start edge, then time for the state to settle
    task edge_start;
        start_cmd = 0;
        cyc(2);
        start_cmd = 1;
        cyc(4);
    endtask
    task clear_faults;
        fault_reset = 1;
        cyc(1);
        fault_reset = 0;
    endtask
    task end_of_test;
        if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Level start held over power-up runs without edge; stop overrides
    task power_up;
        cyc(8);
        chk(motor_running, 1);
        chk(gate_enable, 1);
        stop_cmd = 1;
        cyc(3);
        chk(motor_running, 0);
        stop_cmd = 0;
    endtask
    // Both channels open, running or stopped, every indication code
    task both_open(input logic run, input logic [1:0] sel);
        ind_run_sel = run ? sel : 2'h0;
        ind_stop_sel = run ? 2'h0 : sel;
        if (run) edge_start();
        else begin
            start_cmd = 0;
            cyc(2);
        end
        chk(motor_running, run);
        open_req = 2'h3;
        cyc(6);
        chk({gate_enable, torque_inhibit}, 2'h1);
        chk({inhibit_fault, inhibit_warning}, {sel == 2, sel == 1});
        chk(diag_out[3:2], {sel == 1, sel == 2});
        edge_start();
        chk(motor_running, 0);
        open_req = 0;
        cyc(6);
        chk(motor_running, 0);
        edge_start();
        chk(motor_running, sel != 2);
        clear_faults();
        edge_start();
        chk(motor_running, 1);
    endtask
    // One channel open long enough to be a mismatch trip
    task one_open(input logic [1:0] ch);
        edge_start();
        open_req = ch;
        cyc(14);
        chk(gate_enable, 0);
        chk({channel_two_inhibit_fault, channel_one_inhibit_fault}, ch);
        chk(diag_out[1:0], ch);
        edge_start();
        chk(motor_running, 0);
        open_req = 0;
        cyc(6);
        clear_faults();
        edge_start();
        chk(motor_running, 1);
    endtask
    // Channels open two cycles apart, inside the skew allowance: no trip
    task skew_open;
        open_req = 2'h1;
        cyc(2);
        open_req = 2'h3;
        cyc(6);
        chk({channel_two_inhibit_fault, channel_one_inhibit_fault}, 2'h0);
        chk({gate_enable, torque_inhibit}, 2'h1);
        open_req = 2'h0;
        cyc(6);
        chk(motor_running, 0);
        edge_start();
        chk(motor_running, 1);
    endtask
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        cyc(6);
        rst = 0;
        power_up();
        for (int s = 0; s < 8; s++) both_open(s[2], s[1:0]);
        one_open(2'h1);
        one_open(2'h2);
        skew_open();
        end_of_test();
    end
endmodule // tqim_monitor_tb
